// ### burst_order.sv
// ----------------------------------------------------------------
// column order of one beat within a burst
// ----------------------------------------------------------------
module burst_order
(
	input  wire logic [2:0] start_in,
	input  wire logic [2:0] beat_in,
	input  wire logic       interleave_in,
	output logic      [2:0] column_out
);
	// sequential wraps inside the nibble, interleaved xors the beat in
	always_comb
	begin
		column_out[2] = start_in[2] ^ beat_in[2];
		if (interleave_in)
			column_out[1:0] = start_in[1:0] ^ beat_in[1:0];
		else
			column_out[1:0] = start_in[1:0] + beat_in[1:0];
	end
endmodule // burst_order

// ### ctrl_model.sv
module ctrl_model
(
	output logic        ck_out,
	output logic        cs_n_out,
	output logic        act_n_out,
	output logic        ras_n_out,
	output logic        cas_n_out,
	output logic        we_n_out,
	output logic        grp_out,
	output logic [1:0]  bank_out,
	output logic [13:0] addr_out,
	output logic [15:0] dq_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----
	// link clock and idle pins
	// ----
	// the link clock runs free, like the real controller clock
	initial
	begin
		ck_out = 1'b0;
		cs_n_out = 1'b1;
		{act_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
		{grp_out, bank_out, addr_out} = 17'h0;
		dq_out = 16'h0;
	end
	always #160 ck_out = ~ck_out;

	// ----
	// commands and write data
	// ----
	// pins move at a fall and hold until the next fall, well past the rise
	task automatic issue(input logic [3:0] cmd, input logic [16:0] adr);
		@(negedge ck_out);
		cs_n_out = 1'b0;
		{act_n_out, ras_n_out, cas_n_out, we_n_out} = cmd;
		{grp_out, bank_out, addr_out} = adr;
		@(negedge ck_out);
		cs_n_out = 1'b1;
		{grp_out, bank_out, addr_out} = ~adr; // released address lines never keep their value; command pins keep theirs
	endtask

	// each word is centred on its link edge, two words per link clock
	task automatic burst(input logic [15:0] d [8], input int lat, input int n);
		#(80 + 320 * (lat - 1));
		for (int k = 0; k < n; k++)
		begin
			dq_out = d[k];
			#160;
		end
		dq_out = ~d[n - 1];
	endtask
	// the bench resets the device before use and opens a row before each column access except its one closed-bank read
	// no refresh: the whole run is far shorter than one refresh interval
	// preamble length is set by the bench through preamble_two_in
endmodule // ctrl_model

// ### dram_access.sv
`include "dram_access_consts.svh"

// Operation
// - eight banks in two groups of four
// - activate captures group, bank and row bits
// - column bits give burst start location
// - auto close bit closes row after burst
// - on-the-fly chop bit picks four or eight
// - bursts of eight or four in order
// - two data words per link clock
// - one core access spans four clocks, two when chopped to four
// - additive latency zero, less one, less two
// - sequential or interleaved beat order
// - strobe preamble one or two clocks
module dram_access
	import dram_access_pkg::*;
(
	input  wire logic                    clock_in,
	input  wire logic                    reset_in,
	input  wire logic                    ce_in,
	input  wire logic                    ck_in,
	input  wire logic                    cs_n_in,
	input  wire logic                    act_n_in,
	input  wire logic                    ras_n_in,
	input  wire logic                    cas_n_in,
	input  wire logic                    we_n_in,
	input  wire logic                    group_select_bit_in,
	input  wire logic [1:0]              bank_select_bits_in,
	input  wire logic [13:0]             address_in,
	input  wire logic [`DQ_W-1:0]        dq_in,
	output logic      [`DQ_W-1:0]        dq_out,
	output logic                         dq_oe_out,
	output logic                         dqs_out,
	output logic                         dqs_oe_out,
	input  wire logic [4:0]              read_latency_in,
	input  wire logic [4:0]              write_latency_in,
	input  wire logic [1:0]              additive_latency_in,
	input  wire logic [1:0]              burst_length_in,
	input  wire logic                    interleave_in,
	input  wire logic                    preamble_two_in,
	output logic      [`BANK_COUNT-1:0]  bank_open_out,
	output logic                         busy_out
);
	// ----------------------------------------------------------------
	// pin synchronisers and link clock edges
	// ----------------------------------------------------------------
	logic [`PIN_W-1:0]                  pin_s1_q, pin_s2_q;
	logic [`DQ_W-1:0]                   dq_s1_q, dq_s2_q;
	logic                               ck_s1_q, ck_s2_q, ck_d_q;
	logic                               rise, fall, edge_ev;

	// every pin passes two flops; only the second stage is read, and the link clock also feeds a third flop for edges
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			pin_s1_q <= '1;
			pin_s2_q <= '1;
			dq_s1_q  <= '0;
			dq_s2_q  <= '0;
			ck_s1_q  <= 1'b0;
			ck_s2_q  <= 1'b0;
			ck_d_q   <= 1'b0;
		end
		else if (ce_in)
		begin
			pin_s1_q <= {cs_n_in, act_n_in, ras_n_in, cas_n_in, we_n_in,
				group_select_bit_in, bank_select_bits_in, address_in};
			pin_s2_q <= pin_s1_q;
			dq_s1_q  <= dq_in;
			dq_s2_q  <= dq_s1_q;
			ck_s1_q  <= ck_in;
			ck_s2_q  <= ck_s1_q;
			ck_d_q   <= ck_s2_q;
		end
	end

	// a frozen block sees no edges, so no event fires while ce is low
	assign rise    = ce_in & ck_s2_q & ~ck_d_q;
	assign fall    = ce_in & ~ck_s2_q & ck_d_q;
	assign edge_ev = rise | fall;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic                    cs_n, act_n;
	logic [2:0]              cmd;
	logic [`BANK_W-1:0]      bank;
	logic [`ROW_W-1:0]       row;
	logic [`COL_W-1:0]       col;
	logic                    act_ev, rd_ev, wr_ev, close_ev, acc_ev;
	burst_state_t            state_q, state_d;

	assign cs_n  = pin_s2_q[21];
	assign act_n = pin_s2_q[20];
	assign cmd   = pin_s2_q[19:17];
	assign bank  = pin_s2_q[16:14];
	// during activate the write-enable pin is the top row bit
	assign row   = {pin_s2_q[17], pin_s2_q[13:0]};
	assign col   = pin_s2_q[`COL_W-1:0];

	assign act_ev   = rise & ~cs_n & ~act_n;
	assign rd_ev    = rise & ~cs_n & act_n & (cmd == `CMD_READ);
	assign wr_ev    = rise & ~cs_n & act_n & (cmd == `CMD_WRITE);
	assign close_ev = rise & ~cs_n & act_n & (cmd == `CMD_CLOSE);

	// ----------------------------------------------------------------
	// bank state
	// ----------------------------------------------------------------
	logic [`BANK_COUNT-1:0]             open_q, open_d;
	logic [`BANK_COUNT-1:0][`ROW_W-1:0] row_q, row_d;
	logic [`BANK_W-1:0]                 bank_q, bank_d;
	logic                               ap_q, ap_d, end_ev;

	// a column command to a closed bank is dropped, not queued
	assign acc_ev = (rd_ev | wr_ev) & (state_q == ST_IDLE) & open_q[bank];

	// per bank: activate opens, close command or auto close shuts
	genvar b;
	generate
		for (b = 0; b < `BANK_COUNT; b++)
		begin : g_bank
			assign open_d[b] = (act_ev & (bank == b)) |
				(open_q[b] & ~(close_ev & ((bank == b) | pin_s2_q[`AUTO_CLOSE_BIT]))
				& ~(end_ev & ap_q & (bank_q == b)));
			assign row_d[b]  = (act_ev & (bank == b)) ? row : row_q[b];
		end
	endgenerate

	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			open_q <= '0;
			row_q  <= '0;
		end
		else if (ce_in)
		begin
			open_q <= open_d;
			row_q  <= row_d;
		end
	end

	assign bank_open_out = open_q;

	// ----------------------------------------------------------------
	// burst sequencer
	// ----------------------------------------------------------------
	logic [`LAT_W-1:0]       lat_q, lat_d, lat_load, al, pre_len;
	logic [2:0]              beat_q, beat_d, last_q, last_d, beat_nx, ord;
	logic [`COL_W-1:0]       start_q, start_d;
	logic                    wr_q, wr_d, beat_ev;

	// additive latency is taken from the read latency setting
	always_comb
	begin
		case (additive_latency_in)
			`AL_LESS_ONE: al = {1'b0, read_latency_in} - `LAT_ONE;
			`AL_LESS_TWO: al = {1'b0, read_latency_in} - `LAT_TWO;
			default:      al = '0;
		endcase
	end
	assign lat_load = al + {1'b0, (wr_ev ? write_latency_in : read_latency_in)};
	assign pre_len  = preamble_two_in ? `LAT_TWO : `LAT_ONE;

	// a beat starts on the first-beat rise and on every later edge until the last beat
	assign beat_ev = ((state_q == ST_WAIT || state_q == ST_PREAMBLE) & rise & (lat_q <= `LAT_ONE))
		| ((state_q == ST_BURST) & edge_ev & (beat_q != last_q));
	assign beat_nx = (state_q == ST_BURST) ? beat_q + `BEAT_ONE : '0;
	assign end_ev  = (state_q == ST_BURST) & edge_ev & (beat_q == last_q);

	always_comb
	begin
		state_d = state_q;
		lat_d   = lat_q;
		beat_d  = beat_q;
		last_d  = last_q;
		start_d = start_q;
		bank_d  = bank_q;
		ap_d    = ap_q;
		wr_d    = wr_q;
		case (state_q)
			ST_IDLE:
			begin
				if (acc_ev)
				begin
					state_d = ST_WAIT;
					lat_d   = lat_load;
					start_d = col;
					bank_d  = bank;
					ap_d    = pin_s2_q[`AUTO_CLOSE_BIT];
					wr_d    = wr_ev;
					// chop bit high keeps the full burst
					case (burst_length_in)
						`BL_FIXED_FOUR: last_d = `LAST_CHOP;
						`BL_ON_THE_FLY: last_d = pin_s2_q[`CHOP_BIT] ? `LAST_FULL : `LAST_CHOP;
						default:        last_d = `LAST_FULL;
					endcase
				end
			end
			ST_WAIT, ST_PREAMBLE:
			begin
				if (rise)
				begin
					lat_d = lat_q - `LAT_ONE;
					if (lat_q <= `LAT_ONE)
					begin
						state_d = ST_BURST;
						beat_d  = '0;
					end
					// short latencies get a shortened preamble
					else if (!wr_q && lat_q <= pre_len + `LAT_ONE)
						state_d = ST_PREAMBLE;
				end
			end
			ST_BURST:
			begin
				if (end_ev)
					state_d = ST_IDLE;
				else if (beat_ev)
					beat_d = beat_nx;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			state_q <= ST_IDLE;
			lat_q   <= '0;
			beat_q  <= '0;
			last_q  <= `LAST_FULL;
			start_q <= '0;
			bank_q  <= '0;
			ap_q    <= 1'b0;
			wr_q    <= 1'b0;
		end
		else if (ce_in)
		begin
			state_q <= state_d;
			lat_q   <= lat_d;
			beat_q  <= beat_d;
			last_q  <= last_d;
			start_q <= start_d;
			bank_q  <= bank_d;
			ap_q    <= ap_d;
			wr_q    <= wr_d;
		end
	end

	assign busy_out = (state_q != ST_IDLE);

	// ----------------------------------------------------------------
	// storage and data pins
	// ----------------------------------------------------------------
	logic [`ENTRY_COUNT-1:0][`DQ_W-1:0] mem_q, mem_d;
	logic [`ENTRY_W-1:0]                idx;
	logic [`DQ_W-1:0]                   dq_q, dq_d;
	logic                               dqs_q, dqs_d;

	burst_order u_order
	(
		.start_in      (start_q[2:0]),
		.beat_in       (beat_nx),
		.interleave_in (interleave_in),
		.column_out    (ord)
	);

	// the store is small: rows alias onto one word set per bank
	assign idx = {bank_q, start_q[`STORE_COL_BIT], ord};

	genvar e;
	generate
		for (e = 0; e < `ENTRY_COUNT; e++)
		begin : g_entry
			assign mem_d[e] = (beat_ev & wr_q & (idx == e)) ? dq_s2_q : mem_q[e];
		end
	endgenerate

	// read beats launch on each edge, strobe follows the clock phase
	always_comb
	begin
		dq_d  = dq_q;
		dqs_d = dqs_q;
		if (beat_ev && !wr_q)
		begin
			dq_d  = mem_q[idx];
			dqs_d = rise;
		end
		else if (state_q != ST_BURST)
			dqs_d = 1'b0;
	end

	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			mem_q <= '0;
			dq_q  <= '0;
			dqs_q <= 1'b0;
		end
		else if (ce_in)
		begin
			mem_q <= mem_d;
			dq_q  <= dq_d;
			dqs_q <= dqs_d;
		end
	end

	assign dq_out     = dq_q;
	assign dqs_out    = dqs_q;
	assign dq_oe_out  = (state_q == ST_BURST) & ~wr_q;
	assign dqs_oe_out = ((state_q == ST_BURST) | (state_q == ST_PREAMBLE)) & ~wr_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (reset_in);

	bank_open_a: assert property (act_ev |=> open_q[$past(bank)] && row_q[$past(bank)] == $past(row))
		else $error("activate did not open the row");
	closed_bank_a: assert property ((rd_ev | wr_ev) && state_q == ST_IDLE && !open_q[bank]
		|=> state_q == ST_IDLE)
		else $error("access to closed bank accepted");
	start_col_a: assert property (acc_ev |=> start_q == $past(col))
		else $error("burst start column wrong");
	auto_close_a: assert property (end_ev && ap_q |=> !open_q[$past(bank_q)])
		else $error("auto close left bank open");
	chop_select_a: assert property (acc_ev && burst_length_in == `BL_ON_THE_FLY
		&& !pin_s2_q[`CHOP_BIT] |=> last_q == `LAST_CHOP)
		else $error("on-the-fly chop not taken");
	beat_range_a: assert property (state_q == ST_BURST |-> beat_q <= last_q)
		else $error("beat past burst end");
	beat_edge_a: assert property (state_q == ST_BURST && $changed(beat_q)
		|-> $past(edge_ev))
		else $error("beat advanced without link edge");
	beat_step_a: assert property (state_q == ST_BURST && edge_ev && beat_q != last_q
		|=> beat_q == $past(beat_q) + `BEAT_ONE)
		else $error("beat did not step on edge");
	al_value_a: assert property (acc_ev && rd_ev && additive_latency_in == `AL_LESS_ONE
		|=> lat_q == {$past(read_latency_in), 1'b0} - `LAT_ONE)
		else $error("additive latency less one wrong");
	order_mode_a: assert property (interleave_in |-> ord == (start_q[2:0] ^ beat_nx))
		else $error("interleaved order wrong");
	preamble_a: assert property (state_q == ST_PREAMBLE |-> dqs_oe_out && !dqs_out && !dq_oe_out)
		else $error("preamble strobe not held low");
endmodule // dram_access

// ### dram_access_consts.svh
`ifndef DRAM_ACCESS_CONSTS_SVH
`define DRAM_ACCESS_CONSTS_SVH

// ----------------------------------------------------------------
// array shape
// ----------------------------------------------------------------
`define BANK_COUNT     8
`define BANK_W         3
`define ROW_W          15
`define COL_W          10
`define DQ_W           16
`define ENTRY_COUNT    128
`define ENTRY_W        7
`define STORE_COL_BIT  3
`define PIN_W          22

// ----------------------------------------------------------------
// command decode, {row strobe, column strobe, write enable}, low active
// ----------------------------------------------------------------
`define CMD_READ       3'h5
`define CMD_WRITE      3'h4
`define CMD_CLOSE      3'h2
`define AUTO_CLOSE_BIT 10
`define CHOP_BIT       12

// ----------------------------------------------------------------
// mode encodings and counts
// ----------------------------------------------------------------
`define AL_ZERO        2'h0
`define AL_LESS_ONE    2'h1
`define AL_LESS_TWO    2'h2
`define BL_FIXED_EIGHT 2'h0
`define BL_ON_THE_FLY  2'h1
`define BL_FIXED_FOUR  2'h2
`define LAST_FULL      3'h7
`define LAST_CHOP      3'h3
`define LAT_W          6
`define LAT_ONE        6'h01
`define LAT_TWO        6'h02
`define BEAT_ONE       3'h1

`endif

// ### dram_access_pkg.sv
package dram_access_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PREAMBLE, ST_BURST} burst_state_t;
endpackage

// ### tb_dram_access.sv
`include "dram_access_consts.svh"

module tb_dram_access;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock_in;
	logic        reset_in;
	logic        ce;
	logic        ck;
	logic        cs_n;
	logic        act_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic        grp;
	logic [1:0]  bank;
	logic [13:0] addr;
	logic [15:0] dq_w;
	logic [15:0] dq_r;
	logic        dq_oe;
	logic        dqs;
	logic        dqs_oe;
	logic        busy;
	logic [7:0]  open;
	logic [4:0]  rl;
	logic [4:0]  wl;
	logic [1:0]  al;
	logic [1:0]  bl;
	logic        il;
	logic        pre;
	logic [15:0] mem [8][16];
	int          err_count;
	int          n_checks;

	always #20 clock_in = ~clock_in;

	ctrl_model u_ctrl_model (.ck_out(ck), .cs_n_out(cs_n), .act_n_out(act_n),
		.ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .grp_out(grp),
		.bank_out(bank), .addr_out(addr), .dq_out(dq_w));

	dram_access u_dram_access (.clock_in(clock_in), .reset_in(reset_in), .ce_in(ce),
		.ck_in(ck), .cs_n_in(cs_n), .act_n_in(act_n), .ras_n_in(ras_n), .cas_n_in(cas_n),
		.we_n_in(we_n), .group_select_bit_in(grp), .bank_select_bits_in(bank),
		.address_in(addr), .dq_in(dq_w), .dq_out(dq_r), .dq_oe_out(dq_oe), .dqs_out(dqs),
		.dqs_oe_out(dqs_oe), .read_latency_in(rl), .write_latency_in(wl),
		.additive_latency_in(al), .burst_length_in(bl), .interleave_in(il),
		.preamble_two_in(pre), .bank_open_out(open), .busy_out(busy));

	// ----
	// helpers
	// ----
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic [2:0] col_of(logic [2:0] s, logic [2:0] k, logic i);
		return {s[2] ^ k[2], i ? s[1:0] ^ k[1:0] : s[1:0] + k[1:0]};
	endfunction

	// latency in link clocks including the additive part
	function automatic int lat_of(logic [4:0] base);
		return base + (al == 2'h1 ? rl - 1 : al == 2'h2 ? rl - 2 : 0);
	endfunction

	// bounded wait for the end of a column access
	task automatic settle;
		int i;
		for (i = 0; i < 3000 && busy !== 1'b0; i++)
			@(negedge clock_in);
		if (i == 3000)
		begin
			err_count++;
			stop_test();
		end
	endtask

	task automatic act(input logic [2:0] b);
		logic [14:0] row;
		row = 15'($urandom);
		u_ctrl_model.issue({3'h3, row[14]}, {b, row[13:0]});
		#400;
		check(open[b], 1'b1);
	endtask

	// full burst from column zero of the chosen half, fixed eight beats
	task automatic wr(input logic [2:0] b, input logic hi);
		logic [15:0] d [8];
		foreach (d[k]) d[k] = 16'($urandom);
		u_ctrl_model.issue({1'b1, `CMD_WRITE}, {b, 14'({hi, 3'h0})});
		u_ctrl_model.burst(d, lat_of(wl), 8);
		foreach (d[k]) mem[b][{hi, col_of(3'h0, 3'(k), il)}] = d[k];
		settle();
	endtask

	// samples fall at link edge plus five system clocks, 60 ns before each beat ends
	task automatic rd(input logic [2:0] b, input logic [3:0] s, input logic eight,
		input logic ac);
		int  n;
		int  lat;
		int  i;
		time t0;
		time ts;
		n = (bl == 2'h2 || (bl == 2'h1 && !eight)) ? 4 : 8;
		lat = lat_of(rl);
		u_ctrl_model.issue({1'b1, `CMD_READ}, {b, 14'({eight, 1'b0, ac, 6'h0, s})});
		t0 = $time;
		ts = 0;
		for (i = 0; i < 2000 && dq_oe !== 1'b1; i++)
		begin
			@(negedge clock_in);
			if (dqs_oe === 1'b1 && ts == 0)
			begin
				ts = $time;
				check(dqs, 1'b0);
			end
		end
		if (i == 2000)
		begin
			err_count++;
			stop_test();
		end
		// first beat shows three system clocks after the last latency rise
		check(32'(($time - t0 + 40) / 320), 32'(lat));
		check(32'(($time - ts) / 320), 32'(pre + 1));
		#80;
		for (int k = 0; k < n; k++)
		begin
			check(dq_r, mem[b][{s[3], col_of(s[2:0], 3'(k), il)}]);
			check({dq_oe, dqs}, {1'b1, ~k[0]});
			#160;
		end
		#120;
		check({busy, dq_oe, dqs_oe, dqs}, 4'h0);
		check(open[b], !ac);
	endtask

	// ----
	// main sequence
	// ----
	initial
	begin
		logic [2:0] b;
		logic       hi;
		clock_in = 1'b0;
		reset_in = 1'b1;
		ce = 1'b1;
		{rl, wl, al, bl, il, pre} = 16'h0;
		err_count = 0;
		n_checks = 0;
		void'($urandom(32'h2DE1));
		repeat (10) @(negedge clock_in);
		check({open, busy, dq_oe, dqs_oe}, 11'h0);
		reset_in = 1'b0;
		repeat (8) @(negedge clock_in);
		for (int k = 0; k < 8; k++) act(3'(k));
		check(open, 8'hFF);
		u_ctrl_model.issue({1'b1, `CMD_CLOSE}, 17'h0400);
		#400;
		check(open, 8'h00);
		// a read to a closed bank is dropped without any answer
		u_ctrl_model.issue({1'b1, `CMD_READ}, 17'h0);
		#800;
		check(busy, 1'b0);
		// a frozen block must not take an activate seen on its pins
		ce = 1'b0;
		u_ctrl_model.issue({3'h3, 1'b0}, 17'h0);
		#400;
		check(open, 8'h00);
		ce = 1'b1;
		$display("test open close done");
		for (int t = 0; t < 12; t++)
		begin
			@(negedge clock_in);
			b = 3'($urandom);
			hi = 1'($urandom);
			rl = 5'(3 + $urandom % 6);
			wl = 5'(2 + $urandom % 5);
			al = 2'($urandom % 3);
			{il, pre} = 2'($urandom);
			bl = 2'h0;
			act(b);
			wr(b, hi);
			bl = 2'($urandom % 3);
			rd(b, {hi, 3'($urandom)}, 1'($urandom), 1'($urandom));
			$display("test burst %0d done", t);
		end
		stop_test();
	end
endmodule // tb_dram_access
